// ===== hw/sbc_pkg.sv
// package: command codes, bank states and timing counts for the sdram bank state machine
package sbc_pkg;
  // command pin pattern {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_BURST_STOP = 4'h6;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_ACTIVATE = 4'h3;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_MODE_SET = 4'h0;
  // address layout
  localparam int ADDR_W = 12;
  localparam int BANK_SELECT_BIT = 11;
  localparam int AUTO_PRECHARGE_SELECT_BIT = 10;
  localparam int COL_W = 8;
  // timing, ns and derived cycles at 50 mhz
  localparam int CLK_PERIOD_NS = 20;
  localparam int ROW_PRECHARGE_TIME_NS = 20;
  localparam int ACT_TO_COL_NS = 20;
  localparam int WRITE_RECOVERY_NS = 20;
  localparam int BANK_TO_BANK_ACTIVATE_SPACING_NS = 20;
  localparam int ROW_ACTIVE_MIN_NS = 60;
  localparam int BURST_LEN = 4;
  localparam logic [3:0] PRECHARGE_CYC =
    4'((ROW_PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] ACT_TO_COL_CYC =
    4'((ACT_TO_COL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] WRITE_RECOVERY_CYC =
    4'((WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] BANK_SPACING_CYC =
    4'((BANK_TO_BANK_ACTIVATE_SPACING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] ROW_ACTIVE_MIN_CYC =
    4'((ROW_ACTIVE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] BURST_CYC = 4'(BURST_LEN);
  localparam logic [3:0] TURNAROUND_CYC = 4'h1;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ACTIVATING, ST_ROW_ACTIVE, ST_READ, ST_WRITE,
    ST_WRITE_RECOVERY, ST_PRECHARGING
  } sbc_state_e;
endpackage

// ===== hw/sbc_if.sv
// interface: command pins between controller and sdram device
`timescale 1ns/100ps
interface sbc_if;
  logic cs_b;
  logic ras_b;
  logic cas_b;
  logic we_b;
  logic [11:0] addr;
  modport ctrl (output cs_b, output ras_b, output cas_b, output we_b, output addr);
  modport dev (input cs_b, input ras_b, input cas_b, input we_b, input addr);
endinterface

// ===== hw/sbc_device.sv
// device end: per-bank command state machine of a two-bank sdram
`timescale 1ns/100ps
module sbc_device (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // command pins
  sbc_if.dev pins,
  // status
  output logic [5:0] bank_state_o,
  output logic [1:0] bank_auto_pre_o,
  output logic [15:0] column_o,
  output logic illegal_cmd_o
);
  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  // pins come from outside the clock domain, two stages before decode
  logic [15:0] pin_s1_q;
  logic [15:0] pin_s2_q;
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      pin_s1_q <= 16'hf000;
      pin_s2_q <= 16'hf000;
    end
    else
    begin
      pin_s1_q <= {pins.cs_b, pins.ras_b, pins.cas_b, pins.we_b, pins.addr};
      pin_s2_q <= pin_s1_q;
    end
  end
  logic [3:0] cmd;
  logic [11:0] addr;
  logic sel_bank;
  logic auto_pre;
  assign cmd = pin_s2_q[15] ? sbc_pkg::CMD_NOP : pin_s2_q[15:12];
  assign addr = pin_s2_q[11:0];
  assign sel_bank = addr[sbc_pkg::BANK_SELECT_BIT];
  assign auto_pre = addr[sbc_pkg::AUTO_PRECHARGE_SELECT_BIT];
  // ----------------------------------------
  // per-bank state
  // ----------------------------------------
  sbc_pkg::sbc_state_e state_q [2];
  // unpacked so that each bank's process owns whole variables, one driver each
  logic ap_q [2];
  logic [3:0] cnt_q [2];
  logic [7:0] col_q [2];
  logic bad [2];
  for (genvar b = 0; b < 2; b++)
  begin : g_bank
    logic hit;
    logic pre_hit;
    // precharge-all when a10 is high, else only the selected bank
    assign hit = (sel_bank == 1'(b));
    assign pre_hit = auto_pre | hit;
    always_ff @(posedge clk_i)
    begin
      if (!rst_b_i)
      begin
        state_q[b] <= sbc_pkg::ST_IDLE;
        ap_q[b] <= 1'b0;
        cnt_q[b] <= 4'h0;
        col_q[b] <= 8'h00;
        bad[b] <= 1'b0;
      end
      else
      begin
        bad[b] <= 1'b0;
        if (cnt_q[b] != 4'h0)
          cnt_q[b] <= cnt_q[b] - 4'h1;
        unique case (state_q[b])
          sbc_pkg::ST_IDLE:
          begin
            if (cmd == sbc_pkg::CMD_ACTIVATE && hit)
            begin
              state_q[b] <= sbc_pkg::ST_ACTIVATING;
              cnt_q[b] <= sbc_pkg::ACT_TO_COL_CYC;
            end
            else if (hit && (cmd == sbc_pkg::CMD_READ || cmd == sbc_pkg::CMD_WRITE
                     || cmd == sbc_pkg::CMD_BURST_STOP))
              bad[b] <= 1'b1;
          end
          sbc_pkg::ST_ACTIVATING:
          begin
            // only nop or the other bank's activate, read, write or precharge are legal here
            if (cmd != sbc_pkg::CMD_NOP && (hit || cmd == sbc_pkg::CMD_BURST_STOP
                || cmd == sbc_pkg::CMD_REFRESH || cmd == sbc_pkg::CMD_MODE_SET))
              bad[b] <= 1'b1;
            else if (cnt_q[b] <= 4'h1)
              state_q[b] <= sbc_pkg::ST_ROW_ACTIVE;
          end
          sbc_pkg::ST_ROW_ACTIVE:
          begin
            if (hit && (cmd == sbc_pkg::CMD_READ || cmd == sbc_pkg::CMD_WRITE))
            begin
              state_q[b] <= (cmd == sbc_pkg::CMD_READ) ? sbc_pkg::ST_READ
                                                       : sbc_pkg::ST_WRITE;
              ap_q[b] <= auto_pre;
              col_q[b] <= addr[7:0];
              cnt_q[b] <= sbc_pkg::BURST_CYC;
            end
            else if (cmd == sbc_pkg::CMD_PRECHARGE && pre_hit)
            begin
              state_q[b] <= sbc_pkg::ST_PRECHARGING;
              cnt_q[b] <= sbc_pkg::PRECHARGE_CYC;
            end
            else if ((cmd == sbc_pkg::CMD_ACTIVATE && hit) || cmd == sbc_pkg::CMD_BURST_STOP)
              bad[b] <= 1'b1;
          end
          sbc_pkg::ST_READ, sbc_pkg::ST_WRITE:
          begin
            if (ap_q[b])
            begin
              // auto-precharge bursts cannot be interrupted on this bank
              if ((hit && cmd inside {sbc_pkg::CMD_READ, sbc_pkg::CMD_WRITE,
                   sbc_pkg::CMD_ACTIVATE}) || cmd == sbc_pkg::CMD_BURST_STOP
                  || (cmd == sbc_pkg::CMD_PRECHARGE && pre_hit))
                bad[b] <= 1'b1;
              else if (cnt_q[b] <= 4'h1)
              begin
                if (state_q[b] == sbc_pkg::ST_READ)
                begin
                  state_q[b] <= sbc_pkg::ST_PRECHARGING;
                  cnt_q[b] <= sbc_pkg::PRECHARGE_CYC;
                end
                else
                begin
                  state_q[b] <= sbc_pkg::ST_WRITE_RECOVERY;
                  cnt_q[b] <= sbc_pkg::WRITE_RECOVERY_CYC;
                end
              end
            end
            else if (cmd == sbc_pkg::CMD_BURST_STOP)
              state_q[b] <= sbc_pkg::ST_ROW_ACTIVE;
            else if (hit && (cmd == sbc_pkg::CMD_READ || cmd == sbc_pkg::CMD_WRITE))
            begin
              // interrupt and restart at the new column
              state_q[b] <= (cmd == sbc_pkg::CMD_READ) ? sbc_pkg::ST_READ
                                                       : sbc_pkg::ST_WRITE;
              ap_q[b] <= auto_pre;
              col_q[b] <= addr[7:0];
              cnt_q[b] <= sbc_pkg::BURST_CYC;
            end
            else if (cmd == sbc_pkg::CMD_PRECHARGE && pre_hit)
            begin
              state_q[b] <= sbc_pkg::ST_PRECHARGING;
              cnt_q[b] <= sbc_pkg::PRECHARGE_CYC;
            end
            else if ((cmd == sbc_pkg::CMD_ACTIVATE && hit)
                     || cmd == sbc_pkg::CMD_REFRESH || cmd == sbc_pkg::CMD_MODE_SET)
              bad[b] <= 1'b1;
            else if (cnt_q[b] <= 4'h1)
            begin
              if (state_q[b] == sbc_pkg::ST_READ)
                state_q[b] <= sbc_pkg::ST_ROW_ACTIVE;
              else
              begin
                state_q[b] <= sbc_pkg::ST_WRITE_RECOVERY;
                cnt_q[b] <= sbc_pkg::WRITE_RECOVERY_CYC;
              end
            end
            else
              col_q[b] <= col_q[b] + 8'h01;
          end
          sbc_pkg::ST_WRITE_RECOVERY:
          begin
            if (cnt_q[b] <= 4'h1)
            begin
              state_q[b] <= ap_q[b] ? sbc_pkg::ST_PRECHARGING : sbc_pkg::ST_ROW_ACTIVE;
              cnt_q[b] <= ap_q[b] ? sbc_pkg::PRECHARGE_CYC : 4'h0;
            end
          end
          sbc_pkg::ST_PRECHARGING:
          begin
            // a repeated precharge does not restart the timer
            if (hit && cmd inside {sbc_pkg::CMD_READ, sbc_pkg::CMD_WRITE,
                sbc_pkg::CMD_ACTIVATE, sbc_pkg::CMD_BURST_STOP})
              bad[b] <= 1'b1;
            if (cnt_q[b] <= 4'h1)
            begin
              state_q[b] <= sbc_pkg::ST_IDLE;
              ap_q[b] <= 1'b0;
            end
          end
        endcase
      end
    end
  end
  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      bank_state_o <= 6'h00;
      bank_auto_pre_o <= 2'h0;
      column_o <= 16'h0000;
      illegal_cmd_o <= 1'b0;
    end
    else
    begin
      bank_state_o <= {state_q[1], state_q[0]};
      bank_auto_pre_o <= {ap_q[1], ap_q[0]};
      column_o <= {col_q[1], col_q[0]};
      illegal_cmd_o <= bad[0] | bad[1];
    end
  end
endmodule

// ===== hw/sbc_ctrl.sv
// controller end: issues one command at a time, holding off until timing allows
`timescale 1ns/100ps
module sbc_ctrl (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // user request
  input wire logic req_valid_i,
  input wire logic [3:0] req_cmd_i,
  input wire logic [11:0] req_addr_i,
  output logic req_ready_o,
  // command pins
  sbc_if.ctrl pins
);
  // ----------------------------------------
  // guard timers
  // ----------------------------------------
  // conservative: a request waits while its bank is busy; no bank tracking of bursts
  logic [3:0] act_gap_q;
  logic [3:0] ras_q [2];
  logic [3:0] turn_q;
  logic [1:0] busy_q;
  logic [3:0] busy_cnt_q [2];
  logic bank;
  logic ok;
  assign bank = req_addr_i[sbc_pkg::BANK_SELECT_BIT];
  always_comb
  begin
    ok = 1'b1;
    if (req_cmd_i == sbc_pkg::CMD_ACTIVATE)
      ok = (act_gap_q == 4'h0) && !busy_q[bank];
    else if (req_cmd_i == sbc_pkg::CMD_PRECHARGE)
      ok = (ras_q[0] == 4'h0) && (ras_q[1] == 4'h0);
    else if (req_cmd_i == sbc_pkg::CMD_READ || req_cmd_i == sbc_pkg::CMD_WRITE)
      ok = (turn_q == 4'h0) && !busy_q[bank];
    else if (req_cmd_i == sbc_pkg::CMD_REFRESH || req_cmd_i == sbc_pkg::CMD_MODE_SET)
      ok = (busy_q == 2'h0);
  end
  logic fire;
  assign fire = req_valid_i && ok && req_ready_o;
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      act_gap_q <= 4'h0;
      turn_q <= 4'h0;
      ras_q[0] <= 4'h0;
      ras_q[1] <= 4'h0;
      busy_q <= 2'h0;
      busy_cnt_q[0] <= 4'h0;
      busy_cnt_q[1] <= 4'h0;
    end
    else
    begin
      act_gap_q <= (act_gap_q != 4'h0) ? act_gap_q - 4'h1 : 4'h0;
      turn_q <= (turn_q != 4'h0) ? turn_q - 4'h1 : 4'h0;
      for (int b = 0; b < 2; b++)
      begin
        ras_q[b] <= (ras_q[b] != 4'h0) ? ras_q[b] - 4'h1 : 4'h0;
        busy_cnt_q[b] <= (busy_cnt_q[b] != 4'h0) ? busy_cnt_q[b] - 4'h1 : 4'h0;
        busy_q[b] <= (busy_cnt_q[b] > 4'h1);
      end
      if (fire && req_cmd_i == sbc_pkg::CMD_ACTIVATE)
      begin
        act_gap_q <= sbc_pkg::BANK_SPACING_CYC;
        ras_q[bank] <= sbc_pkg::ROW_ACTIVE_MIN_CYC;
        busy_cnt_q[bank] <= sbc_pkg::ACT_TO_COL_CYC + 4'h1;
        busy_q[bank] <= 1'b1;
      end
      if (fire && (req_cmd_i == sbc_pkg::CMD_READ || req_cmd_i == sbc_pkg::CMD_WRITE))
        turn_q <= sbc_pkg::TURNAROUND_CYC;
    end
  end
  // ----------------------------------------
  // command pins
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      {pins.cs_b, pins.ras_b, pins.cas_b, pins.we_b} <= sbc_pkg::CMD_NOP;
      pins.addr <= 12'h000;
      req_ready_o <= 1'b0;
    end
    else
    begin
      req_ready_o <= 1'b1;
      {pins.cs_b, pins.ras_b, pins.cas_b, pins.we_b} <= fire ? req_cmd_i : sbc_pkg::CMD_NOP;
      if (fire)
        pins.addr <= req_addr_i;
    end
  end
endmodule

// ===== test/sbc_props.sv
// checker: pin and bank state properties of the sdram bank state machine
`timescale 1ns/100ps
module sbc_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // command pins
  input wire logic cs_b,
  input wire logic ras_b,
  input wire logic cas_b,
  input wire logic we_b,
  input wire logic [11:0] addr,
  // device status
  input wire logic [5:0] bank_state_o,
  input wire logic [1:0] bank_auto_pre_o,
  input wire logic illegal_cmd_o
);
  logic [3:0] cmd;
  logic [2:0] s0;
  assign cmd = {cs_b, ras_b, cas_b, we_b};
  assign s0 = bank_state_o[2:0];
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // windows are loose: status trails the pins by a few register stages
  sequence s_act0;
    cmd == sbc_pkg::CMD_ACTIVATE && !addr[11];
  endsequence
  a_act_seen: assert property (
    s_act0 |-> ##[1:5] s0 == sbc_pkg::ST_ACTIVATING)
    else $error("bank 0 never shown activating");
  a_activating_ends: assert property (
    $rose(s0 == sbc_pkg::ST_ACTIVATING) |-> ##[1:2] s0 == sbc_pkg::ST_ROW_ACTIVE)
    else $error("activating bank not row active in time");
  a_stop_read: assert property (
    cmd == sbc_pkg::CMD_BURST_STOP && s0 == sbc_pkg::ST_READ
    |-> ##[1:5] s0 == sbc_pkg::ST_ROW_ACTIVE)
    else $error("burst stop left read unfinished");
  a_stop_write: assert property (
    cmd == sbc_pkg::CMD_BURST_STOP && s0 == sbc_pkg::ST_WRITE
    |-> ##[1:5] s0 == sbc_pkg::ST_ROW_ACTIVE)
    else $error("burst stop left write unfinished");
  a_pre_burst: assert property (
    cmd == sbc_pkg::CMD_PRECHARGE && (!addr[11] || addr[10])
    && (s0 == sbc_pkg::ST_READ || s0 == sbc_pkg::ST_WRITE)
    |-> ##[1:6] s0 == sbc_pkg::ST_PRECHARGING)
    else $error("precharge did not stop the burst");
  a_precharge_idles: assert property (
    $rose(s0 == sbc_pkg::ST_PRECHARGING) |-> ##[1:3] s0 == sbc_pkg::ST_IDLE)
    else $error("precharging bank not idle in time");
  a_recovery_plain: assert property (
    s0 == sbc_pkg::ST_WRITE_RECOVERY && !bank_auto_pre_o[0]
    |-> ##[1:3] s0 == sbc_pkg::ST_ROW_ACTIVE)
    else $error("write recovery did not return to row active");
  a_recovery_auto: assert property (
    s0 == sbc_pkg::ST_WRITE_RECOVERY && bank_auto_pre_o[0]
    |-> ##[1:3] s0 == sbc_pkg::ST_PRECHARGING)
    else $error("auto precharge write did not precharge");
  a_read_auto_pre: assert property (
    s0 == sbc_pkg::ST_READ && bank_auto_pre_o[0] |-> ##[1:6] s0 == sbc_pkg::ST_PRECHARGING)
    else $error("auto precharge read did not precharge");
  a_ras_min: assert property (
    s_act0 |=> !(cmd == sbc_pkg::CMD_PRECHARGE && (!addr[11] || addr[10])) [*2])
    else $error("precharge too soon after activate");
  a_bst_idle_flag: assert property (
    cmd == sbc_pkg::CMD_BURST_STOP && bank_state_o == 6'h00 |-> ##[1:5] illegal_cmd_o)
    else $error("burst stop in idle not flagged");
  cover property (cmd == sbc_pkg::CMD_BURST_STOP && s0 == sbc_pkg::ST_WRITE);
  cover property (s0 == sbc_pkg::ST_WRITE_RECOVERY && bank_auto_pre_o[0]);
  cover property (illegal_cmd_o);
endmodule

// ===== test/sdram_bank_command_state_machine_tb.sv
// testbench: controller and device joined, driven through user requests
`timescale 1ns/100ps
module sdram_bank_command_state_machine_tb;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic [3:0] req_cmd_i = 4'h7;
  logic [11:0] req_addr_i = 12'h000;
  logic req_ready_o;
  logic [5:0] bank_state_o;
  logic [1:0] bank_auto_pre_o;
  logic [15:0] column_o;
  logic illegal_cmd_o;
  int failures = 0;
  int check_count = 0;
  int flags = 0;
  sbc_if link ();
  sbc_ctrl sbc_ctrl_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i),
    .req_cmd_i(req_cmd_i), .req_addr_i(req_addr_i), .req_ready_o(req_ready_o), .pins(link));
  sbc_device sbc_device_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .pins(link),
    .bank_state_o(bank_state_o), .bank_auto_pre_o(bank_auto_pre_o), .column_o(column_o),
    .illegal_cmd_o(illegal_cmd_o));
  sbc_props sbc_props_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b(link.cs_b),
    .ras_b(link.ras_b), .cas_b(link.cas_b), .we_b(link.we_b), .addr(link.addr),
    .bank_state_o(bank_state_o), .bank_auto_pre_o(bank_auto_pre_o),
    .illegal_cmd_o(illegal_cmd_o));
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (illegal_cmd_o === 1'b1) flags++;
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_state(input logic [2:0] got, input logic [2:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // hold the request until the command shows on the pins, then drop it
  task automatic issue(input logic [3:0] c, input logic [11:0] a);
    int n;
    @(negedge clk_i);
    req_valid_i = 1'b1;
    req_cmd_i = c;
    req_addr_i = a;
    n = 0;
    do
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    while ({link.cs_b, link.ras_b, link.cas_b, link.we_b} !== c && n < 20);
    chk_val({link.cs_b, link.ras_b, link.cas_b, link.we_b, link.addr}, {c, a});
    @(negedge clk_i);
    req_valid_i = 1'b0;
  endtask
  // polls every cycle so one-cycle states are not missed
  task automatic expect_bank(input int b, input logic [2:0] st, input logic [7:0] col = 8'h00,
    input logic cc = 1'b0);
    int n;
    logic [2:0] s;
    logic [7:0] c;
    n = 0;
    s = bank_state_o[3*b +: 3];
    c = column_o[8*b +: 8];
    while ((s !== st || (cc && c !== col)) && n < 12)
    begin
      @(negedge clk_i);
      n++;
      s = bank_state_o[3*b +: 3];
      c = column_o[8*b +: 8];
    end
    chk_state(s, st);
    if (cc)
      chk_val({8'h00, c}, {8'h00, col});
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (4000) @(posedge clk_i);
    failures++;
    end_of_test();
  end
  initial
  begin
    repeat (20) @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (2) @(negedge clk_i);
    chk_val({15'h0000, req_ready_o}, 16'h0001);
    issue(sbc_pkg::CMD_ACTIVATE, 12'h000);
    expect_bank(0, sbc_pkg::ST_ACTIVATING);
    expect_bank(0, sbc_pkg::ST_ROW_ACTIVE);
    issue(sbc_pkg::CMD_READ, 12'h012);
    issue(sbc_pkg::CMD_BURST_STOP, 12'h000);
    expect_bank(0, sbc_pkg::ST_ROW_ACTIVE);
    $display("test 1 done");
    issue(sbc_pkg::CMD_READ, 12'h021);
    issue(sbc_pkg::CMD_READ, 12'h034);
    // write follows at once so it lands inside the restarted read burst
    issue(sbc_pkg::CMD_WRITE, 12'h056);
    expect_bank(0, sbc_pkg::ST_READ, 8'h34, 1'b1);
    expect_bank(0, sbc_pkg::ST_WRITE, 8'h56, 1'b1);
    expect_bank(0, sbc_pkg::ST_WRITE_RECOVERY);
    expect_bank(0, sbc_pkg::ST_ROW_ACTIVE);
    $display("test 2 done");
    issue(sbc_pkg::CMD_WRITE, 12'h010);
    issue(sbc_pkg::CMD_READ, 12'h030);
    expect_bank(0, sbc_pkg::ST_READ, 8'h30, 1'b1);
    issue(sbc_pkg::CMD_WRITE, 12'h040);
    issue(sbc_pkg::CMD_WRITE, 12'h050);
    // burst stop must reach the bank before the four-beat burst runs out
    issue(sbc_pkg::CMD_BURST_STOP, 12'h000);
    expect_bank(0, sbc_pkg::ST_WRITE, 8'h50, 1'b1);
    expect_bank(0, sbc_pkg::ST_ROW_ACTIVE);
    issue(sbc_pkg::CMD_WRITE, 12'h005);
    issue(sbc_pkg::CMD_PRECHARGE, 12'h000);
    expect_bank(0, sbc_pkg::ST_PRECHARGING);
    expect_bank(0, sbc_pkg::ST_IDLE);
    $display("test 3 done");
    issue(sbc_pkg::CMD_ACTIVATE, 12'h000);
    issue(sbc_pkg::CMD_READ, 12'h422);
    expect_bank(0, sbc_pkg::ST_READ, 8'h22, 1'b1);
    expect_bank(0, sbc_pkg::ST_PRECHARGING);
    expect_bank(0, sbc_pkg::ST_IDLE);
    issue(sbc_pkg::CMD_ACTIVATE, 12'h000);
    issue(sbc_pkg::CMD_WRITE, 12'h444);
    expect_bank(0, sbc_pkg::ST_WRITE_RECOVERY);
    expect_bank(0, sbc_pkg::ST_PRECHARGING);
    expect_bank(0, sbc_pkg::ST_IDLE);
    $display("test 4 done");
    issue(sbc_pkg::CMD_ACTIVATE, 12'h000);
    issue(sbc_pkg::CMD_ACTIVATE, 12'h800);
    expect_bank(1, sbc_pkg::ST_ROW_ACTIVE);
    expect_bank(0, sbc_pkg::ST_ROW_ACTIVE);
    issue(sbc_pkg::CMD_READ, 12'h033);
    issue(sbc_pkg::CMD_PRECHARGE, 12'h400);
    expect_bank(0, sbc_pkg::ST_PRECHARGING);
    expect_bank(0, sbc_pkg::ST_IDLE);
    expect_bank(1, sbc_pkg::ST_IDLE);
    $display("test 5 done");
    issue(sbc_pkg::CMD_BURST_STOP, 12'h000);
    repeat (6) @(negedge clk_i);
    chk_val(flags[15:0], 16'h0001);
    expect_bank(0, sbc_pkg::ST_IDLE);
    $display("test 6 done");
    end_of_test();
  end
endmodule
